// ==== hw/mpc_panel_ctrl.sv ====
/*
 * Maintenance panel control: panel switches, rotary selectors and buttons
 * steering the microsequencer, store write enable, maintenance requests,
 * a small command buffer and its byte count register; APB status access.
 * Assumes panel inputs are synchronous to mclk but bouncy, and that the
 * microsequencer follows storeAddr/execWord while seqRun is high.
 */
`include "mpc_regs.svh"

module mpc_panel_ctrl #(
  parameter int DEBOUNCE_CYCLES = `MPC_DEBOUNCE_CYC,
  parameter int BUF_DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Panel
  input wire mpc_pkg::mpc_switch_s panelSwitch,
  input wire mpc_pkg::mpc_button_s panelButton,
  input wire mpc_pkg::mpc_rotary_t rotary,
  output logic [11:0] addrDisplay,
  output logic [7:0] dispA,
  output logic [7:0] dispB,
  output logic matchLamp,
  // Control unit side
  input wire logic online,
  input wire logic [11:0] seqNextAddr,
  input wire logic [8:0] storeSense,
  input wire logic cmdDone,
  input wire logic cmdFirstCond,
  input wire logic opEndPoint,
  input wire logic tapeIndicate,
  input wire logic diagSetCmd,
  input wire logic diagClearCmd,
  input wire logic clearIsModeSet1,
  input wire logic [7:0] errorSet,
  input wire logic errorReset,
  output logic [11:0] storeAddr,
  output logic [11:0] backupAddr,
  output logic [7:0] execWord,
  output logic seqRun,
  output logic storeWriteEn,
  output logic diagMode,
  output logic [7:0] errorLatch,
  output logic driveStop,
  output mpc_pkg::mpc_maint_s maintReq,
  output logic [3:0] driveSelect,
  output logic startActivity,
  output logic loadCompare,
  output logic terminateOp,
  output logic reissueCmd,
  output logic [11:0] byteCount,
  output logic [3:0] incrementer
);
  import mpc_pkg::*;

  localparam int PW = $bits(mpc_switch_s) + $bits(mpc_button_s) + 12;
  localparam int AW = $clog2(BUF_DEPTH);

  function automatic logic oddParity(input logic [10:0] v);
    oddParity = ~^v;
  endfunction

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rstMeta;
  logic rstSyncN;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstMeta <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // ****************************************************************
  // Panel input conditioning
  // ****************************************************************
  logic [PW-1:0] panelMeta;
  logic [PW-1:0] panelSync;
  logic [PW-1:0] panelSample;
  logic [PW-1:0] panelStable;
  logic [31:0] tickCount;
  mpc_switch_s sw;
  mpc_button_s btn;
  mpc_button_s btnPrev;
  mpc_button_s press;
  mpc_rotary_t rot;
  logic [11:0] rotAddr;

  // Accept a level only when two samples a debounce period apart agree
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      panelMeta <= '0;
      panelSync <= '0;
      panelSample <= '0;
      panelStable <= '0;
      tickCount <= 32'h0000_0000;
      btnPrev <= '0;
    end else begin
      panelMeta <= {panelSwitch, panelButton, rotary};
      panelSync <= panelMeta;
      btnPrev <= btn;
      if (tickCount >= 32'(DEBOUNCE_CYCLES - 1)) begin
        tickCount <= 32'h0000_0000;
        panelSample <= panelSync;
        if (panelSample == panelSync) begin
          panelStable <= panelSync;
        end
      end else begin
        tickCount <= tickCount + 32'h0000_0001;
      end
    end
  end

  assign {sw, btn, rot} = panelStable;
  assign press = btn & ~btnPrev;
  assign rotAddr = {rot[2], rot[1], rot[0]};

  // ****************************************************************
  // APB registers
  // ****************************************************************
  logic softHalt;
  logic softResume;
  logic apbWrite;
  assign apbWrite = psel && penable && pwrite;
  assign pready = 1'b1;

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      softHalt <= 1'b0;
      softResume <= 1'b0;
    end else begin
      softResume <= 1'b0;
      if (apbWrite && paddr == `MPC_CTRL_ADDR) begin
        softHalt <= pwdata[`MPC_CTRL_HALT_BIT];
        softResume <= pwdata[`MPC_CTRL_RESUME_BIT];
      end
    end
  end

  // ****************************************************************
  // Sequencer control
  // ****************************************************************
  mpc_seq_e seqState;
  logic [2:0] haltCause;
  logic gateOk;
  logic addrHit;
  logic parityBad;
  logic addrStop;
  logic parityStop;
  logic condStop;
  logic resume;
  logic [7:0] heldWord;

  // Online, the address and parity stops act only with panel enable on
  assign gateOk = !online || sw.panelEnable;
  assign addrHit = storeAddr == rotAddr;
  assign parityBad = !(^storeSense);
  assign addrStop = gateOk && sw.stopOnAddr && addrHit;
  assign parityStop = gateOk && sw.stopOnParity && parityBad;
  assign condStop = sw.firstCondStop && cmdDone && cmdFirstCond;
  assign resume = press.start || softResume;
  assign seqRun = seqState == SEQ_RUN && !softHalt;

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      seqState <= SEQ_RUN;
      haltCause <= 3'h0;
    end else begin
      unique case (seqState)
        SEQ_RUN: begin
          if (seqRun && (addrStop || parityStop || condStop)) begin
            seqState <= SEQ_HALT;
            haltCause <= {condStop, parityStop, addrStop};
          end
        end
        SEQ_HALT: begin
          if (resume) begin
            seqState <= SEQ_RUN;
            haltCause <= 3'h0;
          end
        end
      endcase
    end
  end

  // Address and word registers; halted, only an address load moves the addresses, and heldWord tracks unless sweep is on
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      storeAddr <= 12'h000;
      backupAddr <= 12'h000;
      heldWord <= 8'h00;
    end else begin
      if (press.addrLoad) begin
        storeAddr <= rotAddr;
      end else if (seqRun && !addrStop && !parityStop) begin
        backupAddr <= storeAddr;
        if (sw.repeatAddr) begin
          storeAddr <= rotAddr;
        end else if (sw.sweep) begin
          storeAddr <= storeAddr + 12'h001;
        end else begin
          storeAddr <= seqNextAddr;
        end
      end
      if (!sw.sweep) begin
        heldWord <= storeSense[7:0];
      end
    end
  end

  // Sweep executes the word captured when sweep went on
  assign execWord = sw.sweep ? heldWord : storeSense[7:0];

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      matchLamp <= 1'b0;
      addrDisplay <= 12'h000;
      storeWriteEn <= 1'b0;
    end else begin
      // Equality wins over a clear in the same cycle
      if (addrHit) begin
        matchLamp <= 1'b1;
      end else if (press.matchClear) begin
        matchLamp <= 1'b0;
      end
      addrDisplay <= sw.showBackup ? backupAddr : storeAddr;
      storeWriteEn <= sw.storeWrite && sw.cageToggle;
    end
  end

  // ****************************************************************
  // Mode, error and drive controls
  // ****************************************************************
  logic stopPending;
  logic repeatActive;

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      diagMode <= 1'b0;
      errorLatch <= 8'h00;
    end else begin
      if (diagSetCmd) begin
        diagMode <= 1'b1;
      end else if (diagClearCmd && (clearIsModeSet1 || !sw.diagLock)) begin
        diagMode <= 1'b0;
      end
      // Held bits survive reset; new errors always set
      if (errorReset) begin
        errorLatch <= errorSet |
          (sw.errorHold ? errorLatch & `MPC_HOLD_MASK_RESET : 8'h00);
      end else begin
        errorLatch <= errorLatch | errorSet;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      driveStop <= 1'b0;
      maintReq <= '0;
      driveSelect <= 4'h0;
      startActivity <= 1'b0;
      loadCompare <= 1'b0;
      stopPending <= 1'b0;
      repeatActive <= 1'b0;
    end else begin
      driveStop <= sw.autoHalt && tapeIndicate;
      startActivity <= press.start;
      loadCompare <= press.addrLoad;
      maintReq <= '0;
      if (press.start) begin
        driveSelect <= rot[0];
        unique case ({sw.maintHigh, sw.maintLow})
          2'b00: maintReq.runBuffer <= 1'b1;
          2'b01: maintReq.spareActivity <= 1'b1;
          2'b10: maintReq.writeMark <= 1'b1;
          2'b11: maintReq.rewind <= 1'b1;
        endcase
      end
      if (press.stop) begin
        stopPending <= 1'b1;
      end else if (opEndPoint || press.start) begin
        stopPending <= 1'b0;
      end
      if (!sw.repeatCmd || press.stop) begin
        repeatActive <= 1'b0;
      end else if (cmdDone) begin
        repeatActive <= 1'b1;
      end
    end
  end

  assign terminateOp = stopPending && opEndPoint;
  assign reissueCmd = repeatActive && cmdDone && !press.stop;

  // ****************************************************************
  // Command buffer
  // ****************************************************************
  mpc_entry_s bufMem [BUF_DEPTH];
  logic [AW-1:0] bufSel;
  assign bufSel = AW'(rot[2]);

  always_ff @(posedge mclk) begin
    if (press.bufLoad && !sw.byteCountLoad) begin
      bufMem[bufSel] <= '{parity: oddParity({sw.condToggles, rot[1], rot[0]}),
                          cond: sw.condToggles,
                          data: {rot[1], rot[0]}};
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      byteCount <= 12'h000;
      incrementer <= 4'h0;
      dispA <= 8'h00;
      dispB <= 8'h00;
    end else begin
      if (press.bufLoad && sw.byteCountLoad) begin
        byteCount <= rotAddr;
      end
      if (press.incLoad) begin
        incrementer <= rot[2];
      end
      if (press.bufDisplay) begin
        dispA <= bufMem[bufSel].data;
        dispB <= {incrementer, bufMem[bufSel].cond,
                  bufMem[bufSel].parity};
      end
    end
  end

  // ****************************************************************
  // APB read path
  // ****************************************************************
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      `MPC_CTRL_ADDR: prdata = {31'h0, softHalt};
      `MPC_STATUS_ADDR: prdata = {24'h0, repeatActive, stopPending,
                                  diagMode, matchLamp, haltCause,
                                  seqState == SEQ_HALT};
      `MPC_ADDR_ADDR: prdata = {4'h0, backupAddr, 4'h0, storeAddr};
      `MPC_COUNT_ADDR: prdata = {16'h0, incrementer, byteCount};
      `MPC_ERROR_ADDR: prdata = {24'h0, errorLatch};
      default: pslverr = psel && penable;
    endcase
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstSyncN);

  sequence lockedClear;
    sw.diagLock && diagClearCmd && !clearIsModeSet1 && !diagSetCmd;
  endsequence

  sequence sweepOn;
    sw.sweep ##1 sw.sweep;
  endsequence

  diag_lock_a: assert property (lockedClear and diagMode |=> diagMode)
    else $error("diagnostic latch cleared under lock");
  write_gate_a: assert property (storeWriteEn |->
      $past(sw.storeWrite) && $past(sw.cageToggle))
    else $error("store write enabled without both switches");
  addr_loop_a: assert property (seqRun && sw.repeatAddr && !addrStop
      && !parityStop && !press.addrLoad |=> storeAddr == $past(rotAddr))
    else $error("repeat address not followed");
  sweep_hold_a: assert property (sweepOn |-> $stable(execWord))
    else $error("held word changed during sweep");
  addr_stop_a: assert property (seqRun && addrStop |=>
      seqState == SEQ_HALT && haltCause[0])
    else $error("no halt on address compare");
  lamp_hold_a: assert property (matchLamp && !press.matchClear |=>
      matchLamp)
    else $error("match lamp dropped without clear");
  halt_freeze_a: assert property (seqState == SEQ_HALT && !press.addrLoad
      |=> $stable(storeAddr) && $stable(backupAddr))
    else $error("sequencer moved while halted");
  stop_end_a: assert property (press.stop ##1 !opEndPoint [*2] ##1
      opEndPoint |-> terminateOp)
    else $error("stop did not end at termination point");
  auto_halt_a: assert property (sw.autoHalt && tapeIndicate |=>
      driveStop)
    else $error("drive not stopped at marker");
  maint_code_a: assert property (press.start && sw.maintHigh && sw.maintLow
      |=> maintReq.rewind && !maintReq.runBuffer)
    else $error("maintenance code wrongly decoded");
endmodule

// ==== hw/mpc_regs.svh ====
/*
 * Register offsets, field positions, reset values and timing counts for
 * the maintenance panel control block.
 * Assumes a 200 MHz system clock and a 32-bit APB register bus.
 */
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define MPC_CTRL_ADDR 8'h00
`define MPC_STATUS_ADDR 8'h04
`define MPC_ADDR_ADDR 8'h08
`define MPC_COUNT_ADDR 8'h0C
`define MPC_ERROR_ADDR 8'h10

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define MPC_CTRL_HALT_BIT 0
`define MPC_CTRL_RESUME_BIT 1
`define MPC_CTRL_RESET 32'h0000_0000
`define MPC_HOLD_MASK_RESET 8'hFE

// ****************************************************************
// Timing
// ****************************************************************
`define MPC_CLK_NS 5
`define MPC_DEBOUNCE_NS 1000000
`define MPC_DEBOUNCE_CYC ((`MPC_DEBOUNCE_NS + `MPC_CLK_NS - 1) / `MPC_CLK_NS)

`endif

// ==== hw/mpc_pkg.sv ====
/*
 * Types shared by the maintenance panel control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mpc_pkg;

  typedef struct packed {
    logic diagLock;
    logic panelEnable;
    logic errorHold;
    logic storeWrite;
    logic cageToggle;
    logic autoHalt;
    logic maintHigh;
    logic maintLow;
    logic repeatAddr;
    logic sweep;
    logic showBackup;
    logic stopOnAddr;
    logic stopOnParity;
    logic firstCondStop;
    logic byteCountLoad;
    logic repeatCmd;
    logic [2:0] condToggles;
  } mpc_switch_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic addrLoad;
    logic matchClear;
    logic bufDisplay;
    logic bufLoad;
    logic incLoad;
  } mpc_button_s;

  typedef struct packed {
    logic runBuffer;
    logic spareActivity;
    logic writeMark;
    logic rewind;
  } mpc_maint_s;

  typedef struct packed {
    logic parity;
    logic [2:0] cond;
    logic [7:0] data;
  } mpc_entry_s;

  typedef logic [2:0][3:0] mpc_rotary_t;

  typedef enum logic [0:0] {SEQ_RUN, SEQ_HALT} mpc_seq_e;

endpackage

// ==== testbench/mpc_panel_model.sv ====
/*
 * Field engineer panel model: switches, rotary selectors, pushbuttons.
 * Assumes the bench calls its tasks from one process at a time and that
 * mclk is the controller clock; all changes land just after rising edges.
 */
// ****************************************************************
// Panel model
// ****************************************************************
module mpc_panel_model (
  input wire logic mclk,
  output mpc_pkg::mpc_switch_s panelSwitch,
  output mpc_pkg::mpc_button_s panelButton,
  output mpc_pkg::mpc_rotary_t rotary
);
  import mpc_pkg::*;

  initial begin
    panelSwitch = '0;
    panelButton = '0;
    rotary = '0;
  end

  task automatic setSw(input mpc_switch_s v);
    @(posedge mclk);
    panelSwitch <= v;
  endtask

  task automatic setRot(input mpc_rotary_t v);
    @(posedge mclk);
    rotary <= v;
  endtask

  // Real contacts chatter: one short bounce before the steady press
  task automatic press(input int b);
    @(posedge mclk);
    panelButton[b] <= 1'b1;
    @(posedge mclk);
    panelButton[b] <= 1'b0;
    @(posedge mclk);
    panelButton[b] <= 1'b1;
    repeat (14) @(posedge mclk);
    panelButton[b] <= 1'b0;
    repeat (14) @(posedge mclk);
  endtask
endmodule

// ==== testbench/tb_top.sv ====
/*
 * Self-checking bench for the maintenance panel control block.
 * Assumes DEBOUNCE_CYCLES of 4, zero-wait APB, and a panel model
 * that holds each press long enough to pass the debounce.
 */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mpc_pkg::*;

  localparam int B_START = 6;
  localparam int B_ADDR = 4;
  localparam int B_CLR = 3;
  localparam int B_DISP = 2;
  localparam int B_LOAD = 1;
  localparam int B_INC = 0;

  logic mclk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, dispA, dispB, errorSet, errorLatch;
  logic [31:0] pwdata, prdata, rd, seed;
  mpc_switch_s panelSwitch, swv;
  mpc_button_s panelButton;
  mpc_rotary_t rotary, rv;
  mpc_maint_s maintReq;
  logic [11:0] addrDisplay, seqNextAddr, storeAddr, backupAddr, byteCount;
  logic [11:0] nxt;
  logic [8:0] storeSense;
  logic [7:0] execWord;
  logic [3:0] driveSelect, incrementer;
  logic [6:0] acc;
  logic [2:0] cnd;
  logic matchLamp, online, cmdDone, cmdFirstCond, opEndPoint, tapeIndicate;
  logic diagSetCmd, diagClearCmd, clearIsModeSet1, errorReset, er, par;
  logic seqRun, storeWriteEn, diagMode, driveStop, startActivity;
  logic loadCompare, terminateOp, reissueCmd;
  int badCount, comparisons;
  int bufMem[16];

  mpc_panel_ctrl #(.DEBOUNCE_CYCLES(4), .BUF_DEPTH(16)) dut (
    .mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .panelSwitch, .panelButton, .rotary, .addrDisplay,
    .dispA, .dispB, .matchLamp, .online, .seqNextAddr, .storeSense,
    .cmdDone, .cmdFirstCond, .opEndPoint, .tapeIndicate, .diagSetCmd,
    .diagClearCmd, .clearIsModeSet1, .errorSet, .errorReset, .storeAddr,
    .backupAddr, .execWord, .seqRun, .storeWriteEn, .diagMode,
    .errorLatch, .driveStop, .maintReq, .driveSelect, .startActivity,
    .loadCompare, .terminateOp, .reissueCmd, .byteCount, .incrementer
  );

  mpc_panel_model pm (.mclk, .panelSwitch, .panelButton, .rotary);

  always #2.5 mclk = ~mclk;

  // ****************************************************************
  // Bench tasks
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    comparisons++;
    if (g !== e) begin
      badCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      badCount++;
      printVerdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    pm.setSw(swv);
    repeat (14) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic watch(input int n);
    acc = '0;
    repeat (n) begin
      @(negedge mclk);
      acc = acc | {maintReq, driveStop, startActivity, loadCompare};
    end
  endtask

  task automatic push(input int b);
    fork
      pm.press(b);
      watch(40);
    join
  endtask

  task automatic printVerdict();
    if (badCount == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run is about 1300 cycles; this is some fifteen times that
  initial begin
    #100000;
    badCount++;
    printVerdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {online, cmdDone, cmdFirstCond, opEndPoint, tapeIndicate} = '0;
    {diagSetCmd, diagClearCmd, clearIsModeSet1, errorSet, errorReset} = '0;
    seqNextAddr = '0;
    storeSense = 9'h100;
    swv = '0;
    seed = 32'h0000_1B07;
    badCount = 0;
    comparisons = 0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    for (int k = 0; k < 4; k++) begin
      swv.storeWrite = k[0];
      swv.cageToggle = k[1];
      settle();
      chk(storeWriteEn, k == 3);
    end
    for (int it = 0; it < 3; it++) begin
      rv = rnd();
      cnd = rnd();
      pm.setRot(rv);
      swv.byteCountLoad = 1'b1;
      swv.condToggles = cnd;
      settle();
      push(B_INC);
      chk(incrementer, rv[2]);
      push(B_LOAD);
      chk(byteCount, rv);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, {16'h0, rv[2], rv});
      swv.byteCountLoad = 1'b0;
      settle();
      push(B_LOAD);
      par = ~^{cnd, rv[1], rv[0]};
      bufMem[rv[2]] = {par, cnd, rv[1], rv[0]};
      push(B_DISP);
      chk(dispA, bufMem[rv[2]][7:0]);
      chk(dispB, {rv[2], bufMem[rv[2]][10:8], bufMem[rv[2]][11]});
    end
    apb(1'b1, 8'h00, 32'h1);
    @(negedge mclk);
    chk(seqRun, 1'b0);
    push(B_ADDR);
    chk(storeAddr, rv);
    chk(acc[0], 1'b1);
    chk(addrDisplay, rv);
    swv.showBackup = 1'b1;
    settle();
    chk(addrDisplay, 12'h0);
    @(posedge mclk);
    seqNextAddr <= rv;
    swv.showBackup = 1'b0;
    swv.stopOnAddr = 1'b1;
    settle();
    apb(1'b1, 8'h00, 32'h0);
    repeat (6) @(negedge mclk);
    chk(seqRun, 1'b0);
    chk(storeAddr, rv);
    chk(matchLamp, 1'b1);
    nxt = rv + 12'h1;
    @(posedge mclk);
    seqNextAddr <= nxt;
    swv.stopOnAddr = 1'b0;
    settle();
    chk({seqRun, storeAddr}, {1'b0, rv});
    push(B_START);
    chk({seqRun, storeAddr}, {1'b1, nxt});
    chk(matchLamp, 1'b1);
    push(B_CLR);
    chk(matchLamp, 1'b0);
    for (int c = 0; c < 4; c++) begin
      swv.maintHigh = c[1];
      swv.maintLow = c[0];
      settle();
      push(B_START);
      chk(acc[6:3], 4'h8 >> c);
      chk(acc[1], 1'b1);
      chk(driveSelect, rv[0]);
    end
    @(posedge mclk);
    online <= 1'b1;
    seqNextAddr <= rv;
    swv.stopOnAddr = 1'b1;
    settle();
    chk({seqRun, storeAddr}, {1'b1, rv});
    for (int k = 0; k < 2; k++) begin
      swv.autoHalt = k[0];
      settle();
      fork
        begin
          @(posedge mclk);
          tapeIndicate <= 1'b1;
          @(posedge mclk);
          tapeIndicate <= 1'b0;
        end
        watch(6);
      join
      chk(acc[2], k[0]);
    end
    swv.diagLock = 1'b1;
    settle();
    @(posedge mclk);
    diagSetCmd <= 1'b1;
    @(posedge mclk);
    diagSetCmd <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      diagClearCmd <= 1'b1;
      clearIsModeSet1 <= k[0];
      @(posedge mclk);
      diagClearCmd <= 1'b0;
      @(negedge mclk);
      chk(diagMode, !k[0]);
    end
    swv.errorHold = 1'b1;
    settle();
    @(posedge mclk);
    errorSet <= 8'hFF;
    @(posedge mclk);
    errorSet <= 8'h00;
    errorReset <= 1'b1;
    @(posedge mclk);
    errorReset <= 1'b0;
    @(negedge mclk);
    chk(errorLatch, 8'hFE);
    push(5);
    @(posedge mclk);
    opEndPoint <= 1'b1;
    @(negedge mclk);
    chk(terminateOp, 1'b1);
    @(posedge mclk);
    opEndPoint <= 1'b0;
    swv.repeatCmd = 1'b1;
    settle();
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      cmdDone <= 1'b1;
      @(negedge mclk);
      chk(reissueCmd, k[0]);
      @(posedge mclk);
      cmdDone <= 1'b0;
    end
    @(posedge mclk);
    storeSense <= 9'h15A;
    swv.sweep = 1'b1;
    settle();
    @(posedge mclk);
    storeSense <= 9'h1C3;
    @(negedge mclk);
    chk(execWord, 8'h5A);
    nxt = storeAddr;
    @(negedge mclk);
    chk(storeAddr, nxt + 12'h001);
    printVerdict();
  end
endmodule
